// *** fbssm_pkg.sv ***
// What this block does
// RULE1: Objects addressed by 16-bit index, fields by 8-bit subindex.
// RULE2: Decode index areas: comm 1000-1FFF, device 2000-5FFF, profile 6000-9FFF.
// RULE3: Service-data server answers reads and accepts writes only where permitted.
// RULE4: Each PDO enabled by valid bit 31 of subindex 01 of its comm object.
// RULE5: Process data carries no overhead and is never acknowledged.
// RULE6: Controller requests state changes; device acknowledges after completing them.
// RULE7: No application exchange in Init; controller configures registers there.
// RULE8: Pre-Operational runs mailbox, process data exchange disabled.
// RULE9: Stay in Pre-Operational until a valid process data mapping arrives.
// RULE10: Safe-Operational delivers inputs and ignores controller output data.
// RULE11: Operational delivers inputs and applies received output data.
// RULE12: Single-step transitions start or stop mailbox, input and output update.
// RULE13: Operational to Pre-Operational stops output and input update.
// RULE14: Safe-Operational to Init stops input update and mailbox.
// RULE15: Operational to Init stops output update and mailbox.
// RULE16: Init to Bootstrap enters boot mode; leaving it returns to Init, restarts.
// RULE17: Record services lost on each transition.
// RULE18: Loss while drive enabled (status low nibble 7) sets fault code 60. The code raises no fault on PreOp to Init.
// RULE19: SDO and emergency active in PreOp, SafeOp, Op; inactive in Init.
// RULE20: PDO off in Init, PreOp; transmit only in SafeOp; all in Op.
// RULE21: With process data off, reject drive control through service data.
// RULE22: Report state code: 1 Init, 2 PreOp, 3 Boot, 4 SafeOp, 8 Op.
// RULE23: Undefined transition requests are refused; state stays.
//
// Purpose: constants and types for the fieldbus slave state machine.
// Assumes: one 50 MHz clock.
// Notes: none.
package fbssm_pkg;

   typedef enum logic [3:0] {
      ST_INIT = 4'h1,
      ST_PREOP = 4'h2,
      ST_BOOT = 4'h3,
      ST_SAFEOP = 4'h4,
      ST_OP = 4'h8
   } fbssm_state_t;

   typedef enum logic [1:0] {
      AREA_OTHER = 2'h0,
      AREA_COMM = 2'h1,
      AREA_DEVICE = 2'h2,
      AREA_PROFILE = 2'h3
   } fbssm_area_t;

   typedef struct packed {
      logic [15:0] index;
      logic [7:0] subindex;
      logic write;
      logic [31:0] wdata;
   } fbssm_sdo_req_t;

   typedef struct packed {
      logic sdo;
      logic tpdo;
      logic rpdo;
   } fbssm_lost_t;

   localparam logic [15:0] AREA_COMM_LO = 16'h1000;
   localparam logic [15:0] AREA_DEVICE_LO = 16'h2000;
   localparam logic [15:0] AREA_PROFILE_LO = 16'h6000;
   localparam logic [15:0] AREA_RESV_LO = 16'hA000;
   localparam int PDO_VALID_BIT = 31;
   localparam logic [7:0] PDO_COMM_SUBIDX = 8'h01;
   localparam logic [15:0] RPDO_COMM_IDX = 16'h1400;
   localparam logic [15:0] TPDO_COMM_IDX = 16'h1800;
   localparam logic [15:0] RPDO_MAP_IDX = 16'h1600;
   localparam logic [15:0] TPDO_MAP_IDX = 16'h1A00;
   localparam logic [15:0] CTRL_WORD_IDX = 16'h6040;
   localparam logic [3:0] DRIVE_ENABLED_NIB = 4'h7;
   localparam logic [7:0] FAULT_LOST_CTRL = 8'h60;
   localparam logic [7:0] FAULT_NONE = 8'h00;
   localparam logic [3:0] ERR_NONE = 4'h0;
   localparam logic [3:0] ERR_NO_OBJ = 4'h1;
   localparam logic [3:0] ERR_READ_ONLY = 4'h2;
   localparam logic [3:0] ERR_NO_CTRL = 4'h3;
   localparam logic [3:0] ERR_NO_MBOX = 4'h4;
   localparam int ACK_DELAY_CYC = 2;
   localparam int RESTART_CYC = 4;

endpackage : fbssm_pkg

// *** fbssm_sdo.sv ***
// Purpose: service-data server over a small dictionary.
// Assumes: requests are one-cycle strobes.
// Notes: answers one cycle after the strobe.
`timescale 1ns/1ps
module fbssm_sdo
   import fbssm_pkg::*;
#(
   parameter int N_OBJ = 8
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   // Service gating
   input wire logic mbox_on_i,
   input wire logic pdo_on_i,
   input wire logic clear_i,
   // Request and answer
   input wire logic req_i,
   input fbssm_sdo_req_t req_data_i,
   output logic ack_o,
   output logic [31:0] rdata_o,
   output logic [3:0] err_o,
   output fbssm_area_t area_o,
   // Dictionary contents seen by the state machine
   output logic rpdo_valid_o,
   output logic tpdo_valid_o,
   output logic map_valid_o,
   output logic ctrl_wr_o,
   output logic [15:0] ctrl_word_o
);

   // Table of dictionary entries; index and subindex address each one
   logic [15:0] obj_idx [N_OBJ];
   logic [7:0] obj_sub [N_OBJ];
   logic [N_OBJ-1:0] obj_wr_ok;
   logic [31:0] mem_reg [N_OBJ];

   assign obj_idx[0] = RPDO_COMM_IDX;
   assign obj_sub[0] = PDO_COMM_SUBIDX;
   assign obj_idx[1] = TPDO_COMM_IDX;
   assign obj_sub[1] = PDO_COMM_SUBIDX;
   assign obj_idx[2] = RPDO_MAP_IDX;
   assign obj_sub[2] = 8'h00;
   assign obj_idx[3] = TPDO_MAP_IDX;
   assign obj_sub[3] = 8'h00;
   assign obj_idx[4] = CTRL_WORD_IDX;
   assign obj_sub[4] = 8'h00;
   assign obj_idx[5] = 16'h203C;
   assign obj_sub[5] = 8'h00;
   assign obj_idx[6] = 16'h203C;
   assign obj_sub[6] = 8'h01;
   assign obj_idx[7] = 16'h203C;
   assign obj_sub[7] = 8'h02;
   // Entry count object is read-only
   assign obj_wr_ok = N_OBJ'(8'hDF);

   function automatic fbssm_area_t area_of(input logic [15:0] idx);
      if (idx >= AREA_RESV_LO || idx < AREA_COMM_LO) return AREA_OTHER;
      else if (idx >= AREA_PROFILE_LO) return AREA_PROFILE;
      else if (idx >= AREA_DEVICE_LO) return AREA_DEVICE;
      else return AREA_COMM;
   endfunction : area_of

   logic [N_OBJ-1:0] hit;
   always_comb begin
      for (int i = 0; i < N_OBJ; i++) begin
         hit[i] = (obj_idx[i] == req_data_i.index) && (obj_sub[i] == req_data_i.subindex); // RULE1
      end
   end

   wire any_hit = |hit;
   wire wr_allowed = |(hit & obj_wr_ok);
   wire is_ctrl = hit[4];
   wire ctrl_blocked = is_ctrl && req_data_i.write && !pdo_on_i; // RULE21
   wire do_write = req_i && mbox_on_i && req_data_i.write && wr_allowed && !ctrl_blocked;
   logic [31:0] rd_sel;
   always_comb begin
      rd_sel = 32'h0;
      for (int i = 0; i < N_OBJ; i++) begin
         if (hit[i]) rd_sel = (i == 5) ? 32'h2 : mem_reg[i];
      end
   end
   wire [3:0] err_next = !mbox_on_i ? ERR_NO_MBOX :
                         !any_hit ? ERR_NO_OBJ :
                         ctrl_blocked ? ERR_NO_CTRL :
                         (req_data_i.write && !wr_allowed) ? ERR_READ_ONLY : ERR_NONE; // RULE3

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         for (int i = 0; i < N_OBJ; i++) mem_reg[i] <= 32'h0;
         ack_o <= 1'b0;
         rdata_o <= 32'h0;
         err_o <= ERR_NONE;
         area_o <= AREA_OTHER;
         ctrl_wr_o <= 1'b0;
      end else begin
         ack_o <= req_i;
         ctrl_wr_o <= do_write && is_ctrl;
         if (req_i) begin
            err_o <= err_next;
            area_o <= area_of(req_data_i.index); // RULE2
            rdata_o <= (err_next == ERR_NONE && !req_data_i.write) ? rd_sel : 32'h0;
         end
         // Restart wipes the mapping back to empty
         if (clear_i) begin
            for (int i = 0; i < N_OBJ; i++) mem_reg[i] <= 32'h0;
         end else begin
            for (int i = 0; i < N_OBJ; i++) begin
               if (do_write && hit[i]) mem_reg[i] <= req_data_i.wdata; // RULE3
            end
         end
      end
   end

   assign rpdo_valid_o = mem_reg[0][PDO_VALID_BIT]; // RULE4
   assign tpdo_valid_o = mem_reg[1][PDO_VALID_BIT]; // RULE4
   assign map_valid_o = (mem_reg[2] != 32'h0) || (mem_reg[3] != 32'h0);
   assign ctrl_word_o = mem_reg[4][15:0];

endmodule : fbssm_sdo

// *** fbssm_top.sv ***
// Purpose: slave state machine with service start/stop and fault code.
// Assumes: requests are one-cycle strobes from the network controller.
// Notes: state change acknowledged after a short settle delay.
`timescale 1ns/1ps
module fbssm_top
   import fbssm_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   // State change request
   input wire logic st_req_i,
   input fbssm_state_t st_req_code_i,
   output logic st_ack_o,
   output logic st_refused_o,
   output logic [3:0] state_code_o,
   // Service data
   input wire logic sdo_req_i,
   input fbssm_sdo_req_t sdo_req_data_i,
   output logic sdo_ack_o,
   output logic [31:0] sdo_rdata_o,
   output logic [3:0] sdo_err_o,
   output logic [1:0] sdo_area_o,
   // Process data
   input wire logic rx_pdo_valid_i,
   input wire logic [31:0] rx_pdo_data_i,
   input wire logic [31:0] drive_inputs_i,
   output logic tx_pdo_valid_o,
   output logic [31:0] tx_pdo_data_o,
   output logic out_apply_o,
   output logic [31:0] drive_outputs_o,
   // Drive status and fault
   input wire logic [15:0] drive_status_word_i,
   output logic [7:0] comm_fault_code_o,
   output logic fault_strobe_o,
   output logic [2:0] lost_o,
   // Services and control
   output logic mbox_on_o,
   output logic emcy_on_o,
   output logic in_upd_o,
   output logic out_upd_o,
   output logic boot_o,
   output logic restart_o,
   output logic ctrl_wr_o,
   output logic [15:0] ctrl_word_o
);

   fbssm_state_t state_reg, state_next, target_reg;
   logic busy_reg;
   logic [2:0] cnt_reg;
   logic rpdo_valid, tpdo_valid, map_valid, ctrl_wr, sdo_ack;
   logic [15:0] ctrl_word;
   logic [31:0] sdo_rdata;
   logic [3:0] sdo_err;
   fbssm_area_t sdo_area;

   // Single-step and direct transitions allowed from each state
   function automatic logic legal(input fbssm_state_t f, input fbssm_state_t t);
      unique case (f)
         ST_INIT: return t == ST_PREOP || t == ST_BOOT;
         ST_PREOP: return t == ST_INIT || t == ST_SAFEOP;
         ST_SAFEOP: return t == ST_INIT || t == ST_PREOP || t == ST_OP;
         ST_OP: return t == ST_INIT || t == ST_PREOP || t == ST_SAFEOP;
         ST_BOOT: return t == ST_INIT;
         default: return 1'b0;
      endcase
   endfunction : legal

   // Services each state runs
   wire mbox_of_next = state_next != ST_INIT && state_next != ST_BOOT; // RULE12 RULE19
   wire in_of_next = state_next == ST_SAFEOP || state_next == ST_OP; // RULE20 RULE10
   wire out_of_next = state_next == ST_OP; // RULE11 RULE20

   // Requests are taken only when idle and the target is reachable
   wire map_ok = st_req_code_i != ST_SAFEOP || state_reg != ST_PREOP || map_valid; // RULE9
   wire take = st_req_i && !busy_reg && legal(state_reg, st_req_code_i) && map_ok; // RULE6
   wire refuse = st_req_i && !take; // RULE23
   wire from_boot = target_reg == ST_INIT && state_reg == ST_BOOT;
   wire [2:0] done_len = from_boot ? 3'(RESTART_CYC - 1) : 3'(ACK_DELAY_CYC - 1);
   wire finish = busy_reg && cnt_reg == done_len;
   assign state_next = finish ? target_reg : state_reg;

   // Services lost by the completed transition
   wire lost_sdo = mbox_on_o && !mbox_of_next; // RULE17 RULE14 RULE15
   wire lost_tpdo = in_upd_o && !in_of_next; // RULE17 RULE13
   wire lost_rpdo = out_upd_o && !out_of_next; // RULE17 RULE13
   wire pi_only = state_reg == ST_PREOP && state_next == ST_INIT;
   wire drive_enabled = drive_status_word_i[3:0] == DRIVE_ENABLED_NIB;
   wire raise = finish && (lost_sdo || lost_tpdo || lost_rpdo) && !pi_only
                && drive_enabled; // RULE18

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_reg <= ST_INIT;
         target_reg <= ST_INIT;
         busy_reg <= 1'b0;
         cnt_reg <= 3'h0;
      end else begin
         if (take) begin
            busy_reg <= 1'b1;
            target_reg <= st_req_code_i;
            cnt_reg <= 3'h0;
         end else if (finish) begin
            busy_reg <= 1'b0;
         end else if (busy_reg) begin
            cnt_reg <= cnt_reg + 3'h1;
         end
         state_reg <= state_next; // RULE16
      end
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_ack_o <= 1'b0;
         st_refused_o <= 1'b0;
         state_code_o <= ST_INIT;
         mbox_on_o <= 1'b0;
         emcy_on_o <= 1'b0;
         in_upd_o <= 1'b0;
         out_upd_o <= 1'b0;
         boot_o <= 1'b0;
         restart_o <= 1'b0;
         comm_fault_code_o <= FAULT_NONE;
         fault_strobe_o <= 1'b0;
         lost_o <= 3'h0;
      end else begin
         st_ack_o <= finish; // RULE6
         st_refused_o <= refuse; // RULE23
         state_code_o <= state_next; // RULE22
         mbox_on_o <= mbox_of_next; // RULE8 RULE7
         emcy_on_o <= mbox_of_next; // RULE19
         in_upd_o <= in_of_next;
         out_upd_o <= out_of_next;
         boot_o <= state_next == ST_BOOT; // RULE16
         restart_o <= finish && from_boot; // RULE16
         fault_strobe_o <= raise;
         if (finish) lost_o <= {lost_sdo, lost_tpdo, lost_rpdo}; // RULE17
         if (raise) comm_fault_code_o <= FAULT_LOST_CTRL; // RULE18
      end
   end

   // Process data: sent and applied without any handshake back
   wire tx_go = in_upd_o && tpdo_valid; // RULE10 RULE4 RULE5
   wire rx_go = out_upd_o && rpdo_valid && rx_pdo_valid_i; // RULE11 RULE10 RULE5

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tx_pdo_valid_o <= 1'b0;
         tx_pdo_data_o <= 32'h0;
         out_apply_o <= 1'b0;
         drive_outputs_o <= 32'h0;
         sdo_ack_o <= 1'b0;
         sdo_rdata_o <= 32'h0;
         sdo_err_o <= ERR_NONE;
         sdo_area_o <= 2'h0;
         ctrl_wr_o <= 1'b0;
         ctrl_word_o <= 16'h0;
      end else begin
         tx_pdo_valid_o <= tx_go;
         if (tx_go) tx_pdo_data_o <= drive_inputs_i;
         out_apply_o <= rx_go;
         if (rx_go) drive_outputs_o <= rx_pdo_data_i;
         sdo_ack_o <= sdo_ack;
         sdo_rdata_o <= sdo_rdata;
         sdo_err_o <= sdo_err;
         sdo_area_o <= sdo_area;
         ctrl_wr_o <= ctrl_wr;
         ctrl_word_o <= ctrl_word;
      end
   end

   // Mailbox off in Init and Bootstrap, so no service data there
   fbssm_sdo #(
      .N_OBJ(8)
   ) u_sdo (
      .clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .mbox_on_i(mbox_on_o), // RULE7 RULE19
      .pdo_on_i(out_upd_o), // RULE21
      .clear_i(restart_o),
      .req_i(sdo_req_i),
      .req_data_i(sdo_req_data_i),
      .ack_o(sdo_ack),
      .rdata_o(sdo_rdata),
      .err_o(sdo_err),
      .area_o(sdo_area),
      .rpdo_valid_o(rpdo_valid),
      .tpdo_valid_o(tpdo_valid),
      .map_valid_o(map_valid),
      .ctrl_wr_o(ctrl_wr),
      .ctrl_word_o(ctrl_word)
   );

endmodule : fbssm_top

// *** fbssm_sva.sv ***
// Purpose: port-level checks of the slave state machine.
// Assumes: single clock, reset active low.
// Notes: bound to fbssm_top.
`timescale 1ns/1ps
module fbssm_sva
   import fbssm_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   // Requests
   input wire logic st_req_i,
   input wire logic sdo_req_i,
   input wire logic rx_pdo_valid_i,
   // Answers and levels
   input wire logic st_ack_o,
   input wire logic st_refused_o,
   input wire logic [3:0] state_code_o,
   input wire logic sdo_ack_o,
   input wire logic out_apply_o,
   input wire logic tx_pdo_valid_o,
   input wire logic mbox_on_o,
   input wire logic emcy_on_o,
   input wire logic in_upd_o,
   input wire logic out_upd_o,
   input wire logic ctrl_wr_o,
   input wire logic [7:0] comm_fault_code_o
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!reset_n_i);
   // Boot exit takes the longer restart path
   ack_cause_a: assert property (st_ack_o |-> $past(st_req_i, 3) || $past(st_req_i, 5))
      else $error("state ack without request");
   sdo_answer_a: assert property (sdo_req_i |-> ##2 sdo_ack_o)
      else $error("sdo ack late");
   // A request refused as busy may meet the ack of the one in flight
   refuse_hold_a: assert property (st_refused_o |-> $stable(state_code_o) || st_ack_o)
      else $error("refused request moved state");
   mbox_svc_a: assert property (mbox_on_o == (state_code_o inside {4'h2, 4'h4, 4'h8}))
      else $error("mailbox level wrong");
   emcy_svc_a: assert property (emcy_on_o == mbox_on_o)
      else $error("emergency level wrong");
   in_upd_a: assert property (in_upd_o == (state_code_o inside {4'h4, 4'h8}))
      else $error("input update level wrong");
   out_upd_a: assert property (out_upd_o == (state_code_o == 4'h8))
      else $error("output update level wrong");
   apply_gate_a: assert property (out_apply_o |-> $past(rx_pdo_valid_i) && $past(out_upd_o))
      else $error("output data applied outside op");
   tx_gate_a: assert property (tx_pdo_valid_o |-> $past(in_upd_o))
      else $error("input data sent without update");
   ctrl_gate_a: assert property (ctrl_wr_o |-> $past(out_upd_o, 2))
      else $error("control word written without pdo");
   fault_keep_a: assert property ($past(comm_fault_code_o) == FAULT_LOST_CTRL |->
      comm_fault_code_o == FAULT_LOST_CTRL)
      else $error("fault code lost");
   state_code_a: assert property (state_code_o inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h8})
      else $error("bad state code");
endmodule : fbssm_sva

bind fbssm_top fbssm_sva u_sva (
   .clk_sys_i, .reset_n_i, .st_req_i, .sdo_req_i, .rx_pdo_valid_i, .st_ack_o,
   .st_refused_o, .state_code_o, .sdo_ack_o, .out_apply_o, .tx_pdo_valid_o,
   .mbox_on_o, .emcy_on_o, .in_upd_o, .out_upd_o, .ctrl_wr_o, .comm_fault_code_o
);

// *** fbssm_ctrl_model.sv ***
// Purpose: network controller side, streams process data.
// Assumes: inputs change 1 ns after the edge.
// Notes: output data every other cycle, values move each cycle.
`timescale 1ns/1ps
module fbssm_ctrl_model (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   // Process data towards the drive
   output logic rx_pdo_valid_o,
   output logic [31:0] rx_pdo_data_o,
   output logic [31:0] drive_inputs_o
);
   logic [31:0] cnt_reg = 32'h0;
   initial begin
      rx_pdo_valid_o = 1'b0;
      rx_pdo_data_o = 32'h0;
      drive_inputs_o = 32'h0;
   end
   // Fire and forget: nothing is awaited back
   always @(posedge clk_sys_i) begin
      #1;
      cnt_reg = reset_n_i ? cnt_reg + 32'h1 : 32'h0;
      rx_pdo_valid_o = cnt_reg[0];
      rx_pdo_data_o = ~cnt_reg;
      drive_inputs_o = cnt_reg ^ 32'hA5A50000;
   end
endmodule : fbssm_ctrl_model

// *** fbssm_top_tb.sv ***
// Purpose: self-checking bench of the slave state machine.
// Assumes: controller model streams process data.
// Notes: boot exit comes before the map and reset checks, it clears the dictionary.
`timescale 1ns/1ps
module fbssm_top_tb
   import fbssm_pkg::*;
;
   typedef struct packed {
      logic [3:0] code;
      logic [3:0] stat;
      logic [3:0] exp;
      logic [2:0] svc;
      logic [2:0] lost;
      logic [7:0] fault;
   } fbssm_row_t;
   logic clk_sys_i, reset_n_i, st_req_i, sdo_req_i, rx_pdo_valid_i;
   fbssm_state_t st_req_code_i;
   fbssm_sdo_req_t sdo_req_data_i;
   logic [15:0] drive_status_word_i, ctrl_word_o;
   logic [31:0] rx_pdo_data_i, drive_inputs_i, sdo_rdata_o, tx_pdo_data_o, drive_outputs_o;
   logic st_ack_o, st_refused_o, sdo_ack_o, tx_pdo_valid_o, out_apply_o, fault_strobe_o;
   logic mbox_on_o, emcy_on_o, in_upd_o, out_upd_o, boot_o, restart_o, ctrl_wr_o;
   logic [3:0] state_code_o, sdo_err_o;
   logic [1:0] sdo_area_o;
   logic [7:0] comm_fault_code_o;
   logic [2:0] lost_o;
   logic [31:0] rx_cap, in_cap;
   int error_cnt = 0, compares = 0, n_rst = 0, a, t;
   logic [15:0] aix [7] = '{16'h1000, 16'h1FFF, 16'h2000, 16'h5FFF, 16'h6000, 16'h9FFF, 16'hA000};
   logic [1:0] aexp [7] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h0};
   // From PreOp with mapping in place
   fbssm_row_t rows [16] = '{'{4'h8, 4'h0, 4'h2, 3'h4, 3'h0, 8'h00},
      '{4'h1, 4'h7, 4'h1, 3'h0, 3'h4, 8'h00}, '{4'h2, 4'h0, 4'h2, 3'h4, 3'h0, 8'h00},
      '{4'h4, 4'h0, 4'h4, 3'h6, 3'h0, 8'h00}, '{4'h8, 4'h0, 4'h8, 3'h7, 3'h0, 8'h00},
      '{4'h4, 4'h0, 4'h4, 3'h6, 3'h1, 8'h00}, '{4'h8, 4'h0, 4'h8, 3'h7, 3'h0, 8'h00},
      '{4'h2, 4'h0, 4'h2, 3'h4, 3'h3, 8'h00}, '{4'h4, 4'h0, 4'h4, 3'h6, 3'h0, 8'h00},
      '{4'h2, 4'h0, 4'h2, 3'h4, 3'h2, 8'h00}, '{4'h4, 4'h0, 4'h4, 3'h6, 3'h0, 8'h00},
      '{4'h1, 4'h0, 4'h1, 3'h0, 3'h6, 8'h00}, '{4'h2, 4'h0, 4'h2, 3'h4, 3'h0, 8'h00},
      '{4'h4, 4'h0, 4'h4, 3'h6, 3'h0, 8'h00}, '{4'h8, 4'h0, 4'h8, 3'h7, 3'h0, 8'h00},
      '{4'h1, 4'h7, 4'h1, 3'h0, 3'h7, 8'h60}};

   fbssm_top DUT (.clk_sys_i, .reset_n_i, .st_req_i, .st_req_code_i, .st_ack_o,
      .st_refused_o, .state_code_o, .sdo_req_i, .sdo_req_data_i, .sdo_ack_o, .sdo_rdata_o,
      .sdo_err_o, .sdo_area_o, .rx_pdo_valid_i, .rx_pdo_data_i, .drive_inputs_i,
      .tx_pdo_valid_o, .tx_pdo_data_o, .out_apply_o, .drive_outputs_o,
      .drive_status_word_i, .comm_fault_code_o, .fault_strobe_o, .lost_o, .mbox_on_o,
      .emcy_on_o, .in_upd_o, .out_upd_o, .boot_o, .restart_o, .ctrl_wr_o, .ctrl_word_o);
   fbssm_ctrl_model u_ctrl (.clk_sys_i, .reset_n_i, .rx_pdo_valid_o(rx_pdo_valid_i),
      .rx_pdo_data_o(rx_pdo_data_i), .drive_inputs_o(drive_inputs_i));

   initial begin
      clk_sys_i = 1'b0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i) if (restart_o === 1'b1) n_rst++;
   // Taken at the edge, where the design samples them
   always @(posedge clk_sys_i) begin
      rx_cap = rx_pdo_data_i;
      in_cap = drive_inputs_i;
   end

   task end_of_test;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_of_test
   task tick;
      @(posedge clk_sys_i);
      #1;
   endtask : tick
   task chk(input string s, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic st_go(input logic [3:0] c);
      int n;
      tick;
      st_req_i = 1'b1;
      st_req_code_i = fbssm_state_t'(c);
      tick;
      st_req_i = 1'b0;
      for (n = 0; n < 12 && st_ack_o !== 1'b1 && st_refused_o !== 1'b1; n++) tick;
      if (n == 12) chk("state_answer", 1, 0);
   endtask : st_go
   task automatic sdo(input logic [15:0] ix, input logic [7:0] sx, input logic w,
      input logic [31:0] d);
      int n;
      tick;
      sdo_req_i = 1'b1;
      sdo_req_data_i = '{ix, sx, w, d};
      tick;
      sdo_req_i = 1'b0;
      for (n = 0; n < 8 && sdo_ack_o !== 1'b1; n++) tick;
      if (n == 8) chk("sdo_answer", 1, 0);
   endtask : sdo
   task automatic watch(input int c);
      a = 0;
      t = 0;
      repeat (c) begin
         tick;
         a += (out_apply_o === 1'b1);
         t += (tx_pdo_valid_o === 1'b1);
         if (out_apply_o === 1'b1) chk("rx_data", rx_cap, drive_outputs_o);
         if (tx_pdo_valid_o === 1'b1) chk("tx_data", in_cap, tx_pdo_data_o);
      end
   endtask : watch

   initial begin
      repeat (3000) @(posedge clk_sys_i);
      error_cnt++;
      end_of_test();
   end

   initial begin
      reset_n_i = 1'b0;
      st_req_i = 1'b0;
      sdo_req_i = 1'b0;
      st_req_code_i = ST_INIT;
      sdo_req_data_i = '0;
      drive_status_word_i = 16'h0000;
      repeat (3) @(posedge clk_sys_i);
      #1 reset_n_i = 1'b1;
      chk("reset_state", ST_INIT, state_code_o);
      chk("reset_svc", 0, {mbox_on_o, in_upd_o, out_upd_o, comm_fault_code_o});
      sdo(16'h203C, 8'h00, 1'b0, 32'h0);
      chk("init_sdo", ERR_NO_MBOX, sdo_err_o);
      st_go(4'h2);
      sdo(16'h203C, 8'h00, 1'b0, 32'h0);
      chk("entries", 32'h2, sdo_rdata_o);
      sdo(16'h203C, 8'h00, 1'b1, 32'h5);
      chk("read_only", ERR_READ_ONLY, sdo_err_o);
      sdo(16'h203C, 8'h01, 1'b1, 32'h1234);
      sdo(16'h203C, 8'h01, 1'b0, 32'h0);
      chk("readback", 32'h1234, sdo_rdata_o);
      foreach (aix[k]) begin
         sdo(aix[k], 8'h00, 1'b0, 32'h0);
         chk("area", aexp[k], sdo_area_o);
      end
      st_go(4'h4);
      chk("no_map", 4'h2, state_code_o);
      sdo(CTRL_WORD_IDX, 8'h00, 1'b1, 32'h1);
      chk("ctrl_refused", ERR_NO_CTRL, sdo_err_o);
      sdo(RPDO_COMM_IDX, PDO_COMM_SUBIDX, 1'b1, 32'h80000000);
      sdo(TPDO_COMM_IDX, PDO_COMM_SUBIDX, 1'b1, 32'h80000000);
      sdo(RPDO_MAP_IDX, 8'h00, 1'b1, 32'h1);
      sdo(TPDO_MAP_IDX, 8'h00, 1'b1, 32'h1);
      foreach (rows[k]) begin
         drive_status_word_i = {12'h000, rows[k].stat};
         st_go(rows[k].code);
         chk("fault_strobe", rows[k].fault != 8'h00, fault_strobe_o);
         tick;
         chk("state", rows[k].exp, state_code_o);
         chk("services", rows[k].svc, {mbox_on_o, in_upd_o, out_upd_o});
         chk("emcy", rows[k].svc[2], emcy_on_o);
         chk("fault", rows[k].fault, comm_fault_code_o);
         if (rows[k].lost != 3'h0) chk("lost", rows[k].lost, lost_o);
      end
      drive_status_word_i = 16'h0000;
      st_go(4'h2);
      st_go(4'h4);
      watch(8);
      chk("safe_apply", 0, a);
      chk("safe_tx", 8, t);
      st_go(4'h8);
      watch(8);
      chk("op_apply", 4, a);
      sdo(CTRL_WORD_IDX, 8'h00, 1'b1, 32'hF);
      chk("ctrl_ok", ERR_NONE, sdo_err_o);
      chk("ctrl_word", 16'h000F, ctrl_word_o);
      sdo(RPDO_COMM_IDX, PDO_COMM_SUBIDX, 1'b1, 32'h0);
      tick;
      tick;
      watch(8);
      chk("rpdo_off", 0, a);
      st_go(4'h1);
      st_go(4'h3);
      chk("boot", 4'h3, {state_code_o[3:1], boot_o});
      st_go(4'h1);
      tick;
      chk("restart", 1, n_rst);
      chk("boot_exit", ST_INIT, state_code_o);
      // Leaving boot cleared the mapping
      st_go(4'h2);
      st_go(4'h4);
      chk("map_cleared", 4'h2, state_code_o);
      // Only a reset clears the sticky fault code
      reset_n_i = 1'b0;
      tick;
      reset_n_i = 1'b1;
      chk("fault_reset", FAULT_NONE, comm_fault_code_o);
      chk("rst_state", ST_INIT, state_code_o);
      end_of_test();
   end
endmodule : fbssm_top_tb
